// File: hw/wss_word_consts.vh
// wss_word_consts.vh: offsets, field positions, reset values and timing counts
// for the wheel speed data word encoder; definitions only.
`ifndef WSS_WORD_CONSTS_VH
`define WSS_WORD_CONSTS_VH

// register byte offsets on the wishbone slave
`define REG_CTRL 4'h0
`define REG_MEAS 4'h4
`define REG_WORD 4'h8
`define REG_STAT 4'hC

// control register fields
`define CTRL_ERR_VARIANT 0
`define CTRL_FAULT 1
`define CTRL_DIR_VALID 2
`define CTRL_DIR 3
`define CTRL_CAL_DONE 4
`define CTRL_RESET_VAL 8'h00

// status / interrupt register layout
`define IRQ_WORD_DONE 0
`define IRQ_FAULT 1
`define IRQ_CAL 2
`define IRQ_WIDTH 3

// word bit positions
`define BIT_FLAG0 0
`define BIT_GAUGE_N 1
`define BIT_SPARE 2
`define BIT_DIR_VALID 3
`define BIT_DIR 4
`define BIT_GAUGE_LO 5
`define BIT_GAUGE_HI 7
`define BIT_PARITY 8
`define WORD_BITS 9

// switching field ratio thresholds (amplitude in threshold units)
`define RATIO_1 8'd2
`define RATIO_2 8'd4
`define RATIO_3 8'd8
`define RATIO_4 8'd16
`define RATIO_5 8'd32
`define RATIO_6 8'd64
`define RATIO_7 8'd96

// timing: bit time and pulse width in ns, and the same in 40 ns clock cycles
`define CLK_NS 40
`define BIT_TIME_NS 50000
`define PULSE_TIME_NS 50000
`define BIT_CYCLES 16'd1250
`define PULSE_CYCLES 16'd1250

`endif

// File: hw/wheel_speed_data_word_encoder.v
// wheel_speed_data_word_encoder: builds and sends the nine-bit data word after each
// speed pulse, with wishbone register access and one level interrupt.
// assumes all inputs synchronous to clk_i; speed events come as one-cycle strobes.
//
// How it works
// - nine-bit word follows each speed pulse, bit2 zero
// - error variant: bit0 rises on internal fault
// - reserve variant: bit0 set below twice threshold
// - bit1 gauge invalid flag, one after reset
// - bit3 direction valid flag, zero after reset
// - bit4 rotation direction, zero means positive
// - bits5-7 air gap gauge, LSB at five
// - bit8 gives even parity over word
// - whole frame delayed one constant bit time
// - delay applies always, to every word sent
// - gauge code maps directly, no hysteresis
// - gauge measured and updated only when calibrated
// - uncalibrated: gauge bits hold last value
// - gauge bits zero at power-up
// - gauge code follows amplitude ratio table
// - fault state drives constant low current
// - first uncalibrated pulse sent direction invalid
// - calibrated once offset compensation achieved
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`include "wss_word_consts.vh"

module wheel_speed_data_word_encoder
(
	input wire clk_i, // 25 MHz clock
	input wire rst_i, // synchronous reset, high
	input wire [3:0] adr_i, // wishbone byte address
	input wire [31:0] dat_i, // wishbone write data
	output reg [31:0] dat_o, // wishbone read data
	input wire [3:0] sel_i, // wishbone byte selects
	input wire we_i, // wishbone write enable
	input wire cyc_i, // wishbone cycle
	input wire stb_i, // wishbone strobe
	output reg ack_o, // wishbone acknowledge
	input wire speed_event_i, // one-cycle strobe: magnetic edge seen
	input wire offset_done_i, // level: offset compensation achieved
	input wire fault_i, // level: internal error detected
	input wire [7:0] amplitude_i, // measured amplitude in threshold units
	input wire amplitude_strobe_i, // one-cycle strobe: new amplitude sample
	output reg current_high_o, // high current level on the two-wire line
	output reg fault_state_o, // constant low failure current active
	output reg calibrated_o, // calibrated mode
	output reg irq_o // level interrupt
);

	localparam [15:0] BIT_CNT = `BIT_CYCLES;
	localparam [15:0] PULSE_CNT = `PULSE_CYCLES;

	localparam [4:0] ST_IDLE = 5'b00001;
	localparam [4:0] ST_SHIFT = 5'b00010;
	localparam [4:0] ST_PULSE = 5'b00100;
	localparam [4:0] ST_DATA = 5'b01000;
	localparam [4:0] ST_FAULT = 5'b10000;

	reg [4:0] state;
	reg [7:0] ctrl;
	reg [2:0] gap_gauge;
	reg gauge_valid_n;
	reg gap_reserve_flag;
	reg direction_valid;
	reg rotation_dir;
	reg [8:0] shift_word;
	reg [8:0] last_word;
	reg [3:0] bit_idx;
	reg [15:0] timer;
	reg pending;
	reg first_pulse_done;
	reg [`IRQ_WIDTH-1:0] irq_stat;
	reg [`IRQ_WIDTH-1:0] irq_en;
	reg [`IRQ_WIDTH-1:0] next_irq_stat;
	reg [8:0] next_word;
	reg fault_seen;
	reg [`IRQ_WIDTH-1:0] irq_events;
	wire bus_req;
	wire bus_wr;
	wire fault_now;
	wire err_variant;
	wire wr_ctrl;
	wire wr_irq_en;
	wire wr_clear;
	wire rd_req;
	wire frame_end;
	reg [31:0] next_dat;

	// maps an amplitude ratio straight to its gauge code
	function [2:0] gauge_code;
		input [7:0] amp;
		begin
			if (amp > `RATIO_7)
				gauge_code = 3'h7;
			else if (amp > `RATIO_6)
				gauge_code = 3'h6;
			else if (amp > `RATIO_5)
				gauge_code = 3'h5;
			else if (amp > `RATIO_4)
				gauge_code = 3'h4;
			else if (amp > `RATIO_3)
				gauge_code = 3'h3;
			else if (amp > `RATIO_2)
				gauge_code = 3'h2;
			else if (amp > `RATIO_1)
				gauge_code = 3'h1;
			else
				gauge_code = 3'h0;
		end
	endfunction

	// address match for one register word
	function reg_hit;
		input [3:0] adr;
		input [3:0] offset;
		begin
			reg_hit = (adr == offset);
		end
	endfunction

	// even parity: the parity bit makes the total count of ones even
	function even_parity;
		input [7:0] bits;
		begin
			even_parity = ^bits;
		end
	endfunction

	// a request is taken once; a high ack blocks a second take of the same cycle
	assign bus_req = cyc_i & stb_i & ~ack_o;
	assign bus_wr = bus_req & we_i & sel_i[0];
	assign err_variant = ctrl[`CTRL_ERR_VARIANT];
	assign fault_now = fault_i | ctrl[`CTRL_FAULT];
	// one write strobe for each writable register, one read strobe for all registers
	assign wr_ctrl = bus_wr & reg_hit(adr_i, `REG_CTRL);
	assign wr_irq_en = bus_wr & reg_hit(adr_i, `REG_MEAS);
	assign wr_clear = bus_wr & reg_hit(adr_i, `REG_STAT);
	assign rd_req = bus_req & ~we_i;
	// the last bit time of the parity bit ends the frame
	assign frame_end = (state == ST_DATA) && (timer == 16'h0000) && (bit_idx == 4'd8);

	// word assembly, parity over bits zero to seven
	always @*
	begin
		next_word = 9'h000;
		next_word[`BIT_FLAG0] = err_variant ? fault_now : gap_reserve_flag;
		next_word[`BIT_GAUGE_N] = gauge_valid_n;
		next_word[`BIT_SPARE] = 1'b0;
		next_word[`BIT_DIR_VALID] = direction_valid & first_pulse_done;
		next_word[`BIT_DIR] = rotation_dir;
		next_word[`BIT_GAUGE_HI:`BIT_GAUGE_LO] = gap_gauge;
		next_word[`BIT_PARITY] = even_parity(next_word[7:0]);
	end

	// calibration and air gap measurement
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			calibrated_o <= 1'b0;
			gap_gauge <= 3'h0;
			gauge_valid_n <= 1'b1;
			gap_reserve_flag <= 1'b0;
			direction_valid <= 1'b0;
			rotation_dir <= 1'b0;
		end
		else
		begin
			if (offset_done_i | ctrl[`CTRL_CAL_DONE])
				calibrated_o <= 1'b1;
			// direction fields follow the control register one cycle late
			direction_valid <= ctrl[`CTRL_DIR_VALID];
			rotation_dir <= ctrl[`CTRL_DIR];
			if (amplitude_strobe_i)
			begin
				gap_reserve_flag <= (amplitude_i < `RATIO_1);
				if (calibrated_o)
				begin
					gap_gauge <= gauge_code(amplitude_i);
					gauge_valid_n <= 1'b0;
				end
				// uncalibrated: gauge left untouched
			end
		end
	end

	// frame sequencer: shift, pulse, nine data bits
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state <= ST_IDLE;
			current_high_o <= 1'b0;
			fault_state_o <= 1'b0;
			shift_word <= 9'h000;
			last_word <= 9'h000;
			bit_idx <= 4'h0;
			timer <= 16'h0000;
			pending <= 1'b0;
			first_pulse_done <= 1'b0;
		end
		// reserve variant: a fault cuts any frame and sticks until reset
		else if (fault_now && !err_variant)
		begin
			state <= ST_FAULT;
			current_high_o <= 1'b0;
			fault_state_o <= 1'b1;
			pending <= 1'b0;
		end
		else
		begin
			// a speed event during a frame is kept and served after it
			if (speed_event_i)
				pending <= 1'b1;
			case (state)
			ST_IDLE:
			begin
				current_high_o <= 1'b0;
				if (speed_event_i | pending)
				begin
					state <= ST_SHIFT;
					timer <= BIT_CNT - 16'd1;
					pending <= 1'b0;
				end
			end
			ST_SHIFT:
			begin
				if (timer == 16'h0000)
				begin
					state <= ST_PULSE;
					current_high_o <= 1'b1;
					timer <= PULSE_CNT - 16'd1;
					shift_word <= next_word;
				end
				else
					timer <= timer - 16'd1;
			end
			ST_PULSE:
			begin
				if (timer == 16'h0000)
				begin
					state <= ST_DATA;
					first_pulse_done <= 1'b1;
					bit_idx <= 4'h0;
					current_high_o <= shift_word[0];
					timer <= BIT_CNT - 16'd1;
				end
				else
					timer <= timer - 16'd1;
			end
			ST_DATA:
			begin
				if (timer == 16'h0000)
				begin
					if (bit_idx == 4'd8)
					begin
						state <= ST_IDLE;
						current_high_o <= 1'b0;
						last_word <= shift_word;
					end
					else
					begin
						bit_idx <= bit_idx + 4'd1;
						current_high_o <= shift_word[bit_idx + 4'd1];
						timer <= BIT_CNT - 16'd1;
					end
				end
				else
					timer <= timer - 16'd1;
			end
			ST_FAULT:
			begin
				current_high_o <= 1'b0;
				fault_state_o <= 1'b1;
			end
			default:
				state <= ST_IDLE;
			endcase
		end
	end

	// interrupt events: word sent, fault rising, calibration reached
	always @*
	begin
		irq_events = {`IRQ_WIDTH{1'b0}};
		irq_events[`IRQ_WORD_DONE] = frame_end;
		irq_events[`IRQ_FAULT] = fault_now & ~fault_seen;
		irq_events[`IRQ_CAL] = (offset_done_i | ctrl[`CTRL_CAL_DONE]) & ~calibrated_o;
		next_irq_stat = irq_stat;
		if (wr_clear)
			next_irq_stat = irq_stat & ~dat_i[`IRQ_WIDTH-1:0];
		// events are merged after the clear, so a set wins over a clear
		next_irq_stat = next_irq_stat | irq_events;
	end

	// read data mux, registered below so that dat_o comes from a flip-flop
	always @*
	begin
		next_dat = 32'h00000000;
		case (adr_i)
		`REG_CTRL:
			next_dat = {24'h000000, ctrl};
		`REG_MEAS:
			next_dat = {29'h00000000, irq_en};
		`REG_WORD:
			next_dat = {7'h00, shift_word, 7'h00, last_word};
		`REG_STAT:
			next_dat = {18'h00000, state, fault_state_o, calibrated_o, gauge_valid_n,
				gap_gauge, irq_stat};
		default:
			next_dat = 32'h00000000;
		endcase
	end

	// wishbone slave: one ack, registered one cycle after the request, registers at aligned words
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
			ctrl <= `CTRL_RESET_VAL;
			irq_stat <= {`IRQ_WIDTH{1'b0}};
			irq_en <= {`IRQ_WIDTH{1'b0}};
			irq_o <= 1'b0;
			fault_seen <= 1'b0;
		end
		else
		begin
			ack_o <= bus_req;
			fault_seen <= fault_now;
			irq_stat <= next_irq_stat;
			irq_o <= |(next_irq_stat & irq_en);
			if (wr_ctrl)
				ctrl <= dat_i[7:0];
			if (wr_irq_en)
				irq_en <= dat_i[`IRQ_WIDTH-1:0];
			if (rd_req)
				dat_o <= next_dat;
		end
	end

endmodule // wheel_speed_data_word_encoder

// File: tb/wss_word_properties.sv
// wss_word_properties: port-level checks on the data word encoder.
// assumes one clock domain with rst_i synchronous, active high.
`timescale 1ns/1ps
module wss_word_properties
(
	input wire clk_i, // clock
	input wire rst_i, // reset
	input wire cyc_i, // bus cycle
	input wire stb_i, // bus strobe
	input wire ack_o, // bus acknowledge
	input wire offset_done_i, // offset reached
	input wire current_high_o, // line level
	input wire fault_state_o, // failure current
	input wire calibrated_o // calibrated mode
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
		else $error("ack held too long");
	AST_ACK_REQ: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack missing");
	AST_FAULT_LOW: assert property (fault_state_o |-> !current_high_o)
		else $error("high current in fault state");
	AST_FAULT_HOLD: assert property (fault_state_o |=> fault_state_o)
		else $error("fault state left");
	AST_CAL_HOLD: assert property (calibrated_o |=> calibrated_o)
		else $error("calibrated mode left");
	AST_CAL_ENTER: assert property ($rose(offset_done_i) |-> ##[1:3] calibrated_o)
		else $error("calibration not entered");
	AST_HIGH_MIN: assert property ($rose(current_high_o) |-> current_high_o[*8])
		else $error("short high level");
	AST_LOW_MIN: assert property ($fell(current_high_o) |-> !current_high_o[*8])
		else $error("short low level");
endmodule // wss_word_properties
bind wheel_speed_data_word_encoder wss_word_properties chk (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .offset_done_i(offset_done_i),
	.current_high_o(current_high_o), .fault_state_o(fault_state_o),
	.calibrated_o(calibrated_o));

// File: tb/ecu_model.sv
// ecu_model: decodes the nine-bit word from the line current level.
// assumes a frame opens with a high speed pulse of one bit time.
`timescale 1ns/1ps
module ecu_model
#(
	parameter BIT = 1250
)
(
	input wire clk_i, // clock
	input wire line_i, // high current level
	output logic [8:0] word_o, // decoded word
	output logic done_o // one cycle: word complete
);
	int cnt = 0;
	int idx = 0;
	logic busy = 1'b0;
	initial done_o = 1'b0;
	always @(posedge clk_i)
	begin
		done_o <= 1'b0;
		cnt <= cnt + 1;
		if (!busy && line_i)
		begin
			busy <= 1'b1;
			cnt <= 0;
			idx <= 0;
		end
		else if (busy && idx < 9 && cnt == BIT + BIT / 2 + idx * BIT)
		begin
			// mid-bit sample, bit zero first
			word_o[idx] <= line_i;
			idx <= idx + 1;
			done_o <= (idx == 8);
		end
		else if (busy && cnt == 11 * BIT)
			busy <= 1'b0;
	end
endmodule // ecu_model

// File: tb/wheel_speed_data_word_encoder_test.sv
// wheel_speed_data_word_encoder_test: frames, gauge, interrupt and fault tests.
// assumes 1250-cycle bit time and a one-cycle wishbone ack.
`timescale 1ns/1ps
module wheel_speed_data_word_encoder_test;
	logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, speed_event_i = 0;
	logic offset_done_i = 0, fault_i = 0, amplitude_strobe_i = 0;
	logic [3:0] adr_i = 4'h0, sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0, q;
	logic [7:0] amplitude_i = 8'h00;
	wire [31:0] dat_o;
	wire ack_o, current_high_o, fault_state_o, calibrated_o, irq_o, done;
	wire [8:0] word;
	int n_errors = 0, total_checks = 0;
	logic [7:0] amps [11] = '{8'h02, 8'h03, 8'h05, 8'h09, 8'h11, 8'h21, 8'h41, 8'h61,
		8'h60, 8'h01, 8'h21};
	logic [2:0] codes [11] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h6,
		3'h0, 3'h5};
	wheel_speed_data_word_encoder uut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
		.dat_i(dat_i), .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .ack_o(ack_o), .speed_event_i(speed_event_i),
		.offset_done_i(offset_done_i), .fault_i(fault_i), .amplitude_i(amplitude_i),
		.amplitude_strobe_i(amplitude_strobe_i), .current_high_o(current_high_o),
		.fault_state_o(fault_state_o), .calibrated_o(calibrated_o), .irq_o(irq_o));
	ecu_model ecu (.clk_i(clk_i), .line_i(current_high_o), .word_o(word), .done_o(done));
	initial forever #20 clk_i = ~clk_i;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		{cyc_i, stb_i} <= 2'b00;
	endtask
	task amp(input logic [7:0] a);
		@(posedge clk_i);
		amplitude_i <= a;
		amplitude_strobe_i <= 1'b1;
		@(posedge clk_i);
		amplitude_strobe_i <= 1'b0;
	endtask
	task automatic frame(input logic [8:0] exp);
		int n = 0;
		@(posedge clk_i);
		speed_event_i <= 1'b1;
		@(posedge clk_i);
		speed_event_i <= 1'b0;
		while (current_high_o !== 1'b1 && n < 2000)
		begin
			@(posedge clk_i);
			n++;
		end
		chk(n >= 1248 && n <= 1254, 1);
		do @(posedge clk_i); while (done !== 1'b1);
		chk(word, exp);
		repeat (640) @(posedge clk_i);
	endtask
	task t_reset;
		amp(8'h61);
		wb(0, 4'hC, 0);
		chk(q[8:0], 9'h040);
		wb(1, 4'h2, 32'hFF);
		wb(0, 4'h2, 0);
		chk(q, 0);
		wb(0, 4'h0, 0);
		chk(q, 0);
		$display("reset test done");
	endtask
	task t_frame1;
		wb(1, 4'h4, 1);
		frame(9'h102);
		chk(irq_o, 1);
		wb(1, 4'hC, 7);
		wb(0, 4'hC, 0);
		chk({irq_o, q[2:0]}, 0);
		$display("first frame test done");
	endtask
	task t_gauge;
		offset_done_i <= 1'b1;
		wb(1, 4'h4, 0);
		wb(1, 4'h0, 32'h0C);
		chk(calibrated_o, 1);
		foreach (amps[i])
		begin
			amp(amps[i]);
			wb(0, 4'hC, 0);
			chk(q[5:3], codes[i]);
		end
		$display("gauge test done");
	endtask
	task t_frame2;
		frame(9'h0B8);
		chk(irq_o, 0);
		wb(0, 4'hC, 0);
		chk(q[2:0], 3'h5);
		amp(8'h01);
		frame(9'h119);
		$display("calibrated frame test done");
	endtask
	task t_error;
		amp(8'h21);
		wb(1, 4'h0, 32'h0F);
		frame(9'h1B9);
		chk(fault_state_o, 0);
		$display("error variant test done");
	endtask
	task t_restart;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		chk({fault_state_o, calibrated_o}, 2'b00);
		wb(1, 4'h0, 32'h0C);
		frame(9'h012);
		$display("restart test done");
	endtask
	task t_fault;
		wb(1, 4'h0, 32'h02);
		repeat (3) @(posedge clk_i);
		chk({fault_state_o, current_high_o}, 2'b10);
		$display("fault test done");
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (90000) @(posedge clk_i);
		n_errors++;
		end_of_test;
	end
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_frame1;
		t_gauge;
		t_frame2;
		t_error;
		t_fault;
		t_restart;
		end_of_test;
	end
endmodule // wheel_speed_data_word_encoder_test
